// ==== ccsd_top.sv ====
// top of the clock source select and divider block: register port, root source switch,
// core prescaler, low-speed clock gating and the twelve peripheral dividers.
// assumes all inputs are synchronous to sys_clk and the internal fast oscillator is sys_clk.
`timescale 1ns/1ps
module ccsd_top (
    input wire logic sys_clk, // system clock, also the internal fast oscillator
    input wire logic resetn, // async reset, active low
    input wire logic [7:0] bus_addr, // register byte address
    input wire logic [31:0] bus_wdata, // write data
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    output logic [31:0] bus_rdata, // read data, valid the cycle after bus_rd
    input wire logic pin_clock_input, // external clock pin level
    input wire logic low_speed_internal_osc, // slow oscillator edge as one-cycle pulse
    input wire logic deep_power_mode, // high in hibernate or stop
    output logic root_clock_net, // root clock enable pulse
    output logic system_core_clock, // core clock enable pulse
    output logic low_freq_system_clock, // low-frequency clock enable pulse
    output logic [11:0] periph_gated, // gated form of each divider stage
    output logic [11:0] periph_divided // divided form of each divider stage
);
    ccsd_pkg::ccsd_bus_req_t req;
    ccsd_pkg::ccsd_div_cfg_t div_cfg_reg [ccsd_pkg::NUM_DIVIDERS];
    ccsd_pkg::ccsd_div_out_t div_out [ccsd_pkg::NUM_DIVIDERS];
    logic slow_osc_enable_reg;
    logic [2:0] src_req_reg;
    logic [2:0] src_active_reg;
    logic [2:0] prescale_req_reg;
    logic [2:0] prescale_active;
    ccsd_pkg::ccsd_sw_state_t sw_state_reg;
    ccsd_pkg::ccsd_sw_state_t sw_state_next;
    logic pin_prev_reg;
    logic pin_rise;
    logic root_tick;
    logic core_tick;
    logic slow_tick;
    logic slow_running;

    // ---------------- register port decode ----------------
    assign req.wr = bus_wr;
    assign req.rd = bus_rd;
    assign req.addr = bus_addr;
    assign req.wdata = bus_wdata;

    logic hit_div;
    logic [3:0] div_index;
    logic hit_slow;
    logic hit_sel;
    logic hit_stat;
    logic sel_code_legal;
    logic [31:0] rd_mux;
    logic [31:0] div_read;
    logic [31:0] sel_read;
    logic [31:0] stat_read;

    assign hit_div = (req.addr[1:0] == 2'h0) && (req.addr <= ccsd_pkg::OFS_DIV_LAST);
    assign div_index = req.addr[5:2];
    assign hit_slow = (req.addr == ccsd_pkg::OFS_SLOW_OSC_CONFIG);
    assign hit_sel = (req.addr == ccsd_pkg::OFS_CLOCK_SELECT);
    assign hit_stat = (req.addr == ccsd_pkg::OFS_CLOCK_STATUS);
    localparam int SEL_SRC_MSB = ccsd_pkg::SEL_SRC_LSB + 2;
    localparam int SEL_PRE_MSB = ccsd_pkg::SEL_PRESCALE_LSB + 2;

    // reserved source codes are refused; the field keeps its value
    assign sel_code_legal = (req.wdata[SEL_SRC_MSB:ccsd_pkg::SEL_SRC_LSB]
        == ccsd_pkg::CCSD_SRC_INTERNAL)
        || (req.wdata[SEL_SRC_MSB:ccsd_pkg::SEL_SRC_LSB] == ccsd_pkg::CCSD_SRC_PIN);

    assign div_read = hit_div ? div_cfg_reg[div_index] : 32'h0000_0000;
    assign sel_read = {25'h0000000, prescale_req_reg, 1'b0, src_req_reg};
    assign stat_read = {23'h000000, slow_running, (sw_state_reg != ccsd_pkg::CCSD_SW_IDLE),
        prescale_active, 1'b0, src_active_reg};
    assign rd_mux = hit_div ? div_read
        : hit_slow ? {31'h00000000, slow_osc_enable_reg}
        : hit_sel ? sel_read
        : hit_stat ? stat_read
        : 32'h0000_0000;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_rdata <= 32'h0000_0000;
        end
        else
        begin
            bus_rdata <= req.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ---------------- divider configuration words ----------------
    genvar gi;
    generate
        for (gi = 0; gi < ccsd_pkg::NUM_DIVIDERS; gi++)
        begin : g_cfg
            localparam bit IS_FRAC = ((gi / ccsd_pkg::STAGES_PER_BANK) == ccsd_pkg::FRAC_BANK);
            ccsd_pkg::ccsd_div_cfg_t wr_word;
            logic wr_hit;
            always_comb
            begin
                wr_word = req.wdata;
                wr_word.reserved = '0;
                // integer stages hold no fraction; those bits read as zero
                if (!IS_FRAC)
                begin
                    wr_word.divider_fraction_numerator = '0;
                end
                // the first stage of a bank has nothing to chain from
                if ((gi % ccsd_pkg::STAGES_PER_BANK) == 0)
                begin
                    wr_word.chain_input_select = req.wdata[30];
                end
            end
            assign wr_hit = req.wr && hit_div && (div_index == 4'(gi));
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    div_cfg_reg[gi] <= '0;
                end
                else if (wr_hit)
                begin
                    div_cfg_reg[gi] <= wr_word;
                end
            end
        end
    endgenerate

    // ---------------- control registers ----------------
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            slow_osc_enable_reg <= ccsd_pkg::SLOW_OSC_ENABLE_RESET;
            src_req_reg <= ccsd_pkg::CCSD_SRC_INTERNAL;
            prescale_req_reg <= ccsd_pkg::PRESCALE_RESET;
        end
        else if (req.wr)
        begin
            if (hit_slow)
            begin
                slow_osc_enable_reg <= req.wdata[ccsd_pkg::SLOW_OSC_ENABLE_BIT];
            end
            if (hit_sel)
            begin
                if (sel_code_legal)
                begin
                    src_req_reg <= req.wdata[SEL_SRC_MSB:ccsd_pkg::SEL_SRC_LSB];
                end
                prescale_req_reg <= req.wdata[SEL_PRE_MSB:ccsd_pkg::SEL_PRESCALE_LSB];
            end
        end
    end

    // ---------------- root source and glitch-free switch ----------------
    // pin clock is sampled; at 125 MHz a 48 MHz pin still gives one tick per rise
    assign pin_rise = pin_clock_input && !pin_prev_reg;
    assign root_tick = (src_active_reg == ccsd_pkg::CCSD_SRC_PIN) ? pin_rise : 1'b1;

    // a new source waits for the end of a core period so no runt pulse leaks out
    always_comb
    begin
        sw_state_next = sw_state_reg;
        case (sw_state_reg)
            ccsd_pkg::CCSD_SW_IDLE:
            begin
                if (src_req_reg != src_active_reg)
                begin
                    sw_state_next = ccsd_pkg::CCSD_SW_DRAIN;
                end
            end
            ccsd_pkg::CCSD_SW_DRAIN:
            begin
                if (core_tick)
                begin
                    sw_state_next = ccsd_pkg::CCSD_SW_LOAD;
                end
            end
            ccsd_pkg::CCSD_SW_LOAD:
            begin
                sw_state_next = ccsd_pkg::CCSD_SW_IDLE;
            end
            default:
            begin
                sw_state_next = ccsd_pkg::CCSD_SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sw_state_reg <= ccsd_pkg::CCSD_SW_IDLE;
            src_active_reg <= ccsd_pkg::CCSD_SRC_INTERNAL;
            pin_prev_reg <= 1'b0;
        end
        else
        begin
            sw_state_reg <= sw_state_next;
            pin_prev_reg <= pin_clock_input;
            if (sw_state_reg == ccsd_pkg::CCSD_SW_LOAD)
            begin
                src_active_reg <= src_req_reg;
            end
        end
    end

    // ---------------- core prescaler ----------------
    ccsd_prescaler u_prescaler (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .root_tick(root_tick),
        .code_req(prescale_req_reg),
        .core_tick(core_tick),
        .code_active(prescale_active)
    );

    // ---------------- low-frequency clock ----------------
    // always the slow oscillator; there is no other source for it
    assign slow_running = slow_osc_enable_reg && !deep_power_mode;
    assign slow_tick = slow_running && low_speed_internal_osc;

    // ---------------- peripheral dividers ----------------
    generate
        for (gi = 0; gi < ccsd_pkg::NUM_DIVIDERS; gi++)
        begin : g_div
            localparam bit IS_FRAC = ((gi / ccsd_pkg::STAGES_PER_BANK) == ccsd_pkg::FRAC_BANK);
            logic stage_in;
            if ((gi % ccsd_pkg::STAGES_PER_BANK) == 0)
            begin : g_first
                // chain bit has no effect on the first stage
                assign stage_in = root_tick;
            end
            else
            begin : g_chain
                assign stage_in = div_cfg_reg[gi].chain_input_select
                    ? (div_out[gi-1].gated && root_tick) : root_tick;
            end
            ccsd_divider #(
                .FRAC_EN(IS_FRAC)
            ) u_div (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .in_tick(stage_in),
                .cfg(div_cfg_reg[gi]),
                .out_o(div_out[gi])
            );
            assign periph_gated[gi] = div_out[gi].gated;
            assign periph_divided[gi] = div_out[gi].divided;
        end
    endgenerate

    // ---------------- registered clock outputs ----------------
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            root_clock_net <= 1'b0;
            low_freq_system_clock <= 1'b0;
        end
        else
        begin
            root_clock_net <= root_tick;
            low_freq_system_clock <= slow_tick;
        end
    end
    assign system_core_clock = core_tick;

endmodule : ccsd_top

// ==== ccsd_pkg.sv ====
// package for the clock source select and divider block: register map, field layouts,
// reset values and enumerations shared by the top and its divider stages.
// assumes one 125 MHz sys_clk; every derived clock except the divided divider outputs is a one-cycle enable pulse on it.
package ccsd_pkg;

    // clock rate and nominal low-speed oscillator figures
    localparam int SYS_CLK_HZ = 125000000;
    localparam int SLOW_OSC_NOMINAL_HZ = 32000;
    localparam int PIN_CLOCK_MAX_HZ = 48000000;

    // divider arrangement
    localparam int NUM_BANKS = 4;
    localparam int STAGES_PER_BANK = 3;
    localparam int NUM_DIVIDERS = NUM_BANKS * STAGES_PER_BANK;
    localparam int FRAC_BANK = 3;
    localparam int DIV_VALUE_W = 16;
    localparam int DIV_FRAC_W = 5;
    localparam int DIV_COUNT_W = DIV_VALUE_W + 1;

    // register byte offsets; divider k sits at DIV_BASE + 4*k, k = 3*bank + stage
    localparam logic [7:0] OFS_DIV_BASE = 8'h00;
    localparam logic [7:0] OFS_DIV_LAST = 8'h2C;
    localparam logic [7:0] OFS_SLOW_OSC_CONFIG = 8'h30;
    localparam logic [7:0] OFS_CLOCK_SELECT = 8'h34;
    localparam logic [7:0] OFS_CLOCK_STATUS = 8'h38;

    // field positions in the clock select, status and slow oscillator config words
    localparam int SEL_SRC_LSB = 0;
    localparam int SEL_PRESCALE_LSB = 4;
    localparam int STAT_SWITCH_BUSY_BIT = 7;
    localparam int STAT_SLOW_RUN_BIT = 8;
    localparam int SLOW_OSC_ENABLE_BIT = 0;

    // reset values
    localparam logic SLOW_OSC_ENABLE_RESET = 1'b1;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;

    // high-frequency root source codes; 2..7 reserved
    typedef enum logic [2:0] {
        CCSD_SRC_INTERNAL = 3'b000,
        CCSD_SRC_PIN = 3'b001
    } ccsd_src_t;

    // source switch sequencer
    typedef enum logic [1:0] {
        CCSD_SW_IDLE = 2'b00,
        CCSD_SW_DRAIN = 2'b01,
        CCSD_SW_LOAD = 2'b10
    } ccsd_sw_state_t;

    // one divider configuration word
    typedef struct packed {
        logic enable;
        logic chain_input_select;
        logic [8:0] reserved;
        logic [DIV_FRAC_W-1:0] divider_fraction_numerator;
        logic [DIV_VALUE_W-1:0] value;
    } ccsd_div_cfg_t;

    // software register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ccsd_bus_req_t;

    // outputs of one divider stage
    typedef struct packed {
        logic gated;
        logic divided;
    } ccsd_div_out_t;

endpackage : ccsd_pkg

// ==== ccsd_divider.sv ====
// one peripheral clock divider stage, integer or fractional by parameter.
// assumes in_tick pulses are one sys_clk cycle wide and come from the root or the
// preceding stage; the top picks which.
`timescale 1ns/1ps
module ccsd_divider #(
    parameter bit FRAC_EN = 1'b0
) (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic in_tick, // selected input clock as enable pulse
    input wire ccsd_pkg::ccsd_div_cfg_t cfg, // configuration word
    output ccsd_pkg::ccsd_div_out_t out_o // gated pulse and divided level
);
    logic [ccsd_pkg::DIV_COUNT_W-1:0] cnt_reg;
    logic [ccsd_pkg::DIV_FRAC_W-1:0] acc_reg;
    logic [ccsd_pkg::DIV_FRAC_W:0] acc_sum;
    logic carry;
    logic [ccsd_pkg::DIV_COUNT_W-1:0] period;
    logic [ccsd_pkg::DIV_COUNT_W-1:0] half;
    logic last;
    logic [ccsd_pkg::DIV_COUNT_W-1:0] cnt_next;
    ccsd_pkg::ccsd_div_out_t out_next;

    // fraction accumulates per period; a carry stretches that period by one input tick
    assign acc_sum = {1'b0, acc_reg} + {1'b0, cfg.divider_fraction_numerator};
    assign carry = FRAC_EN && acc_sum[ccsd_pkg::DIV_FRAC_W];
    assign period = {1'b0, cfg.value} + {{(ccsd_pkg::DIV_COUNT_W-1){1'b0}}, 1'b1}
        + {{(ccsd_pkg::DIV_COUNT_W-1){1'b0}}, carry};
    assign half = period >> 1;
    assign last = (cnt_reg == period - {{(ccsd_pkg::DIV_COUNT_W-1){1'b0}}, 1'b1});
    assign cnt_next = last ? '0 : cnt_reg + {{(ccsd_pkg::DIV_COUNT_W-1){1'b0}}, 1'b1};
    // gated: one pulse per period; divided: high floor(N/2), low the rest
    assign out_next.gated = in_tick && last;
    assign out_next.divided = in_tick ? (cnt_next < half) : out_o.divided;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= '0;
            acc_reg <= '0;
            out_o <= '0;
        end
        else if (!cfg.enable)
        begin
            // held low and restarted from zero on the next enable
            cnt_reg <= '0;
            acc_reg <= '0;
            out_o <= '0;
        end
        else
        begin
            out_o <= out_next;
            if (in_tick)
            begin
                cnt_reg <= cnt_next;
                if (last && FRAC_EN)
                begin
                    acc_reg <= acc_sum[ccsd_pkg::DIV_FRAC_W-1:0];
                end
            end
        end
    end

endmodule : ccsd_divider

// power-of-two prescaler for the core clock; code changes land on a period boundary.
module ccsd_prescaler (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic root_tick, // root clock enable pulse
    input wire logic [2:0] code_req, // requested prescale code
    output logic core_tick, // core clock enable pulse, registered
    output logic [2:0] code_active // code now in force
);
    logic [6:0] cnt_reg;
    logic [6:0] mask;
    logic wrap;

    // mask is 2^code - 1, so code 0 gives a core tick on every root tick
    assign mask = 7'((8'h01 << code_active) - 8'h01);
    assign wrap = root_tick && ((cnt_reg & mask) == mask);

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= '0;
            core_tick <= 1'b0;
            code_active <= ccsd_pkg::PRESCALE_RESET;
        end
        else
        begin
            core_tick <= wrap;
            if (wrap)
            begin
                // new code only at a boundary so no runt core period appears
                cnt_reg <= '0;
                code_active <= code_req;
            end
            else if (root_tick)
            begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end

endmodule : ccsd_prescaler

// ==== ccsd_props.sv ====
// port-level checker for ccsd_top: register readback, root source, slow clock gating.
// assumes it is bound into ccsd_top and sees only that module's ports.
`timescale 1ns/1ps
module ccsd_props (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic [7:0] bus_addr, // register byte address
    input wire logic [31:0] bus_wdata, // write data
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    input wire logic [31:0] bus_rdata, // read data
    input wire logic pin_clock_input, // external clock pin
    input wire logic low_speed_internal_osc, // slow oscillator pulse
    input wire logic deep_power_mode, // hibernate or stop
    input wire logic root_clock_net, // root clock pulse
    input wire logic system_core_clock, // core clock pulse
    input wire logic low_freq_system_clock, // slow clock pulse
    input wire logic [11:0] periph_gated, // gated divider outputs
    input wire logic [11:0] periph_divided // divided divider outputs
);
    logic pin_seen_reg, sel_wr_reg, slow_en_reg;
    logic [2:0] src_reg, pre_reg, up_reg;
    logic [11:0] en_reg, en_d1_reg, en_d2_reg;
    wire sel_wr = bus_wr && bus_addr == ccsd_pkg::OFS_CLOCK_SELECT;
    wire div_hit = bus_addr <= ccsd_pkg::OFS_DIV_LAST && bus_addr[1:0] == 2'h0;
    // a stage counts as off only after three quiet cycles, leaving room for the clearing edge
    wire [11:0] div_off = ~(en_reg | en_d1_reg | en_d2_reg);

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {pin_seen_reg, sel_wr_reg, src_reg, up_reg} <= 8'h00;
            slow_en_reg <= ccsd_pkg::SLOW_OSC_ENABLE_RESET;
            pre_reg <= ccsd_pkg::PRESCALE_RESET;
            {en_reg, en_d1_reg, en_d2_reg} <= 36'h0;
        end
        else
        begin
            up_reg <= (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
            sel_wr_reg <= sel_wr_reg | sel_wr;
            pin_seen_reg <= pin_seen_reg | (sel_wr && bus_wdata[2:0] == 3'h1);
            if (sel_wr)
                pre_reg <= bus_wdata[6:4];
            if (sel_wr && bus_wdata[2:0] <= 3'h1)
                src_reg <= bus_wdata[2:0];
            if (bus_wr && bus_addr == ccsd_pkg::OFS_SLOW_OSC_CONFIG)
                slow_en_reg <= bus_wdata[0];
            if (bus_wr && div_hit)
                en_reg[bus_addr[5:2]] <= bus_wdata[31];
            en_d1_reg <= en_reg;
            en_d2_reg <= en_d1_reg;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_read_sel;
        bus_rd && bus_addr == ccsd_pkg::OFS_CLOCK_SELECT;
    endsequence
    sequence s_read_div;
        bus_rd && div_hit;
    endsequence
    sequence s_deep;
        deep_power_mode ##1 deep_power_mode;
    endsequence
    sequence s_slow_off;
        !slow_en_reg [*3];
    endsequence
    sequence s_slow_on;
        (slow_en_reg && !deep_power_mode) [*2];
    endsequence

    property p_sel_read;
        s_read_sel |=> bus_rdata == {25'h0, $past(pre_reg), 1'b0, $past(src_reg)};
    endproperty
    property p_div_read;
        s_read_div |=> bus_rdata[29:21] == 9'h0
            && ($past(bus_addr) >= 8'h24 || bus_rdata[20:16] == 5'h0);
    endproperty
    property p_root_internal;
        !pin_seen_reg && up_reg >= 3'h3 |-> root_clock_net;
    endproperty
    property p_core_div1;
        !sel_wr_reg && up_reg >= 3'h5 |-> system_core_clock;
    endproperty
    property p_lf_source;
        low_freq_system_clock |-> $past(low_speed_internal_osc);
    endproperty
    property p_lf_deep;
        s_deep |-> !low_freq_system_clock;
    endproperty
    property p_lf_off;
        s_slow_off |-> !low_freq_system_clock;
    endproperty
    property p_lf_pass;
        s_slow_on ##0 low_speed_internal_osc |=> low_freq_system_clock;
    endproperty
    property p_div_off;
        ((periph_gated | periph_divided) & div_off) == 12'h0;
    endproperty

    a_sel_read: assert property (p_sel_read) else $error("select readback wrong");
    a_div_read: assert property (p_div_read) else $error("divider readback wrong");
    a_root_internal: assert property (p_root_internal) else $error("root idle");
    a_core_div1: assert property (p_core_div1) else $error("core not div one");
    a_lf_source: assert property (p_lf_source) else $error("slow clock unsourced");
    a_lf_deep: assert property (p_lf_deep) else $error("slow clock in deep mode");
    a_lf_off: assert property (p_lf_off) else $error("slow clock while off");
    a_lf_pass: assert property (p_lf_pass) else $error("slow pulse lost");
    a_div_off: assert property (p_div_off) else $error("disabled stage active");
endmodule : ccsd_props

bind ccsd_top ccsd_props ccsd_props_inst (.sys_clk(sys_clk), .resetn(resetn),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .pin_clock_input(pin_clock_input),
    .low_speed_internal_osc(low_speed_internal_osc), .deep_power_mode(deep_power_mode),
    .root_clock_net(root_clock_net), .system_core_clock(system_core_clock),
    .low_freq_system_clock(low_freq_system_clock), .periph_gated(periph_gated),
    .periph_divided(periph_divided));

// ==== ccsd_testbench.sv ====
// self-checking bench for ccsd_top: register port, source switch, prescaler, dividers.
// assumes sys_clk doubles as the fast oscillator; pin and slow clocks are sped up.
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic pin_clock_input = 1'b0;
    logic low_speed_internal_osc = 1'b0;
    logic deep_power_mode = 1'b0;
    logic pin_run = 1'b0;
    logic rd_d = 1'b0;
    logic [2:0] ph = 3'h0;
    logic [31:0] seed = 32'h8E2A;
    logic [31:0] r;
    logic [31:0] bus_rdata;
    logic root_clock_net, system_core_clock, low_freq_system_clock;
    logic [11:0] periph_gated, periph_divided;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int tests_run = 0;
    int v;

    always #4 sys_clk = ~sys_clk;

    ccsd_top ccsd_top_inst (.sys_clk(sys_clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .pin_clock_input(pin_clock_input), .low_speed_internal_osc(low_speed_internal_osc),
        .deep_power_mode(deep_power_mode), .root_clock_net(root_clock_net),
        .system_core_clock(system_core_clock), .low_freq_system_clock(low_freq_system_clock),
        .periph_gated(periph_gated), .periph_divided(periph_divided));

    // pin clock at a quarter of sys_clk, slow pulse one in eight: scaled to keep the run short
    always @(posedge sys_clk)
    begin
        ph <= ph + 3'h1;
        pin_clock_input <= pin_run ? ph[1] : 1'b0;
        low_speed_internal_osc <= (ph == 3'h0);
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic stop_test();
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %0t read data %h expected %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_count(input int e, input int g);
        tests_run++;
        if (g != e)
        begin
            n_errors++;
            $display("CHECK FAILED %0t pulse count %0d expected %0d", $time, g, e);
        end
    endtask : chk_count

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_rd <= 1'b0;
        bus_addr <= a;
        bus_wdata <= d;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_wr <= 1'b0;
        bus_addr <= a;
        exp_q.push_back(e);
    endtask : rd

    task automatic idle(input int c);
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
        repeat (c) @(posedge sys_clk);
    endtask : idle

    // s: 0..11 gated, 12..23 divided, 24 core, 25 root, 26 slow; unknowns count heavily
    task automatic meas(input int s, input int w, input int e);
        logic b;
        int c;
        c = 0;
        repeat (w)
        begin
            @(posedge sys_clk);
            b = (s < 12) ? periph_gated[s] : (s < 24) ? periph_divided[s - 12] :
                (s == 24) ? system_core_clock : (s == 25) ? root_clock_net :
                low_freq_system_clock;
            c += (b === 1'b1) ? 1 : (b === 1'b0) ? 0 : 1000;
        end
        chk_count(e, c);
    endtask : meas

    always @(posedge sys_clk)
    begin
        if (rd_d)
            chk_word(exp_q.pop_front(), bus_rdata);
        rd_d <= bus_rd;
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(ccsd_pkg::OFS_CLOCK_SELECT, 32'h0);
        rd(ccsd_pkg::OFS_SLOW_OSC_CONFIG, 32'h1);
        rd(8'h00, 32'h0);
        rd(8'h3C, 32'h0);
        rd(ccsd_pkg::OFS_CLOCK_STATUS, 32'h100);
        for (int k = 0; k < 12; k++)
        begin
            r = rnd();
            wr(8'(4 * k), r);
            rd(8'(4 * k), r & ((k >= 9) ? 32'hC01FFFFF : 32'hC000FFFF));
        end
        for (int k = 0; k < 12; k++)
            wr(8'(4 * k), 32'h0);
        v = int'(rnd() % 6) + 1;
        wr(8'h00, 32'h80000000 | 32'(v));
        wr(8'h04, 32'hC0000001);
        wr(8'h0C, 32'hC0000001);
        wr(8'h24, 32'h80100002);
        idle(40);
        meas(0, (v + 1) * 8, 8);
        meas(12, (v + 1) * 8, ((v + 1) / 2) * 8);
        meas(1, (v + 1) * 16, 8);
        meas(3, 16, 8);
        meas(9, 112, 32);
        wr(8'h00, 32'h0);
        idle(3);
        meas(0, 20, 0);
        meas(12, 20, 0);
        wr(8'h04, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h24, 32'h0);
        for (int c = 0; c < 8; c++)
        begin
            wr(ccsd_pkg::OFS_CLOCK_SELECT, 32'(c << 4));
            idle(300);
            meas(24, 4 << c, 4);
        end
        wr(ccsd_pkg::OFS_CLOCK_SELECT, 32'h5);
        rd(ccsd_pkg::OFS_CLOCK_SELECT, 32'h0);
        pin_run <= 1'b1;
        wr(ccsd_pkg::OFS_CLOCK_SELECT, 32'h1);
        // the switch waits out a core period that may still be 128 root ticks long
        idle(160);
        meas(25, 64, 16);
        rd(ccsd_pkg::OFS_CLOCK_STATUS, 32'h101);
        wr(ccsd_pkg::OFS_CLOCK_SELECT, 32'h0);
        idle(40);
        pin_run <= 1'b0;
        idle(4);
        meas(25, 16, 16);
        meas(26, 64, 8);
        wr(ccsd_pkg::OFS_SLOW_OSC_CONFIG, 32'h0);
        idle(4);
        meas(26, 64, 0);
        wr(ccsd_pkg::OFS_SLOW_OSC_CONFIG, 32'h1);
        idle(4);
        deep_power_mode <= 1'b1;
        idle(4);
        meas(26, 64, 0);
        deep_power_mode <= 1'b0;
        idle(2);
        stop_test();
    end

    initial
    begin
        #(8 * 20000);
        n_errors++;
        stop_test();
    end
endmodule : testbench
